// ==== include/mtmr_pkg.sv ====
// Summary of operation
// - 8-bit up-counter, 8-bit modulo register, source selector, nine-value prescaler.
// - reset stops the counter and clears count and modulo to zero.
// - reset selects bus clock and divide by one.
// - modulo zero runs free through the full range; nonzero runs modulo.
// - modulo register accepts any value from 00 to FF.
// - four sources: bus clock, fixed clock, pin rising, pin falling edges.
// - changing source while running keeps the count.
// - prescaler divides by 1 through 256 in powers of two.
// - changing prescale while running keeps the count.
// - counts each tick up to modulo, then wraps to zero.
// - overflow flag sets on the modulo-to-zero transition.
// - modulo write clears count and overflow flag.
// - flag clears on writing 0 after reading status while flag set.
// - new overflow between read and write cancels the clear.
// - counter reset bit write of 1 and modulo write also clear flag.
// - interrupt request is flag and enable together.
// - clearing the stop bit starts counting; unwritten modulo means free running.
// - source codes: 00 bus, 01 fixed, 10 pin falling, 11 pin rising.
// - prescale codes 0 to 8 pick 1 to 256; others pick 256.
// - counter reset bit is write-only, zeroes count and flag, reads 0.
// - stop bit holds the count; reset sets it.
package mtmr_pkg;
    localparam logic [1:0] ADDR_SC  = 2'h0;
    localparam logic [1:0] ADDR_CLK = 2'h1;
    localparam logic [1:0] ADDR_CNT = 2'h2;
    localparam logic [1:0] ADDR_MOD = 2'h3;
    localparam int BIT_TOF  = 7;
    localparam int BIT_OVERFLOW_IRQ_ENABLE = 6;
    localparam int BIT_TRST = 5;
    localparam int BIT_COUNTER_STOP_BIT = 4;
    localparam logic [7:0] ZERO8   = 8'h00;
    localparam logic [3:0] PS_MAX  = 4'h8;
    localparam logic [1:0] SRC_BUS  = 2'h0;
    localparam logic [1:0] SRC_FIX  = 2'h1;
    localparam logic [1:0] SRC_FALL = 2'h2;
    localparam logic [1:0] SRC_RISE = 2'h3;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mtmr_bus_t;
endpackage

// ==== design/mtmr_edge.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// pin synchroniser and source tick select
// ----------------------------------------
module mtmr_edge (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       pin,
    input  wire logic       fixed_tick,
    input  wire logic [1:0] source_sel,
    output logic            tick
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic fx1;
        logic fx2;
        logic fx3;
    } mtmr_edge_t;

    mtmr_edge_t st_reg;
    mtmr_edge_t st_next;

    always_comb begin
        st_next     = st_reg;
        st_next.s1  = pin;
        st_next.s2  = st_reg.s1;
        st_next.s3  = st_reg.s2;
        st_next.fx1 = fixed_tick;
        st_next.fx2 = st_reg.fx1;
        st_next.fx3 = st_reg.fx2;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        case (source_sel)
            mtmr_pkg::SRC_BUS:  tick = 1'b1;
            mtmr_pkg::SRC_FIX:  tick = st_reg.fx2 & ~st_reg.fx3;
            mtmr_pkg::SRC_FALL: tick = ~st_reg.s2 & st_reg.s3;
            default:            tick = st_reg.s2 & ~st_reg.s3;
        endcase
    end
endmodule

// ==== design/mtmr_timer.sv ====
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// ----------------------------------------
// modulo overflow timer
// ----------------------------------------
module mtmr_timer (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       fixed_freq_clock,
    input  wire logic       external_timer_clock_pin,
    output logic            overflow_irq
);
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] modulo;
        logic [7:0] presc;
        logic [3:0] ps;
        logic [1:0] clock_source_select;
        logic       stop;
        logic       overflow_flag;
        logic       overflow_irq_enable;
        logic       armed;
        logic       irq;
        logic [7:0] rdata;
    } mtmr_state_t;

    mtmr_state_t       st_reg;
    mtmr_state_t       st_next;
    mtmr_pkg::mtmr_bus_t bus;
    logic              src_tick;
    logic              tick;
    logic              wrap;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    mtmr_edge u_edge (
        .clock      (clock),
        .nrst       (nrst),
        .pin        (external_timer_clock_pin),
        .fixed_tick (fixed_freq_clock),
        .source_sel (st_reg.clock_source_select),
        .tick       (src_tick)
    );

    // ----------------------------------------
    // prescaler tap select
    // ----------------------------------------
    function automatic logic presc_due(input logic [3:0] ps, input logic [7:0] cnt);
        logic [7:0] mask;
        mask = 8'hFF;
        if (ps < mtmr_pkg::PS_MAX) begin
            mask = 8'(({8'h00, 8'h01} << ps) - 16'h0001);
        end
        presc_due = (cnt & mask) == mask;
    endfunction

    assign tick = ~st_reg.stop & src_tick & presc_due(st_reg.ps, st_reg.presc);
    assign wrap = st_reg.count == st_reg.modulo && st_reg.modulo != mtmr_pkg::ZERO8
                  || st_reg.count == 8'hFF;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        if (~st_reg.stop && src_tick) begin
            st_next.presc = st_reg.presc + 8'h01;
        end
        if (tick) begin
            st_next.count = wrap ? mtmr_pkg::ZERO8 : st_reg.count + 8'h01;
        end
        if (bus.rd && bus.addr == mtmr_pkg::ADDR_SC && st_reg.overflow_flag) begin
            st_next.armed = 1'b1;
        end
        if (bus.wr && bus.addr == mtmr_pkg::ADDR_SC) begin
            st_next.overflow_irq_enable = bus.wdata[mtmr_pkg::BIT_OVERFLOW_IRQ_ENABLE];
            st_next.stop = bus.wdata[mtmr_pkg::BIT_COUNTER_STOP_BIT];
            if (!bus.wdata[mtmr_pkg::BIT_TOF] && st_reg.armed) begin
                st_next.overflow_flag = 1'b0;
            end
            st_next.armed = 1'b0;
            if (bus.wdata[mtmr_pkg::BIT_TRST]) begin
                st_next.count = mtmr_pkg::ZERO8;
                st_next.presc = mtmr_pkg::ZERO8;
                st_next.overflow_flag   = 1'b0;
            end
        end else if (bus.wr && bus.addr == mtmr_pkg::ADDR_CLK) begin
            st_next.clock_source_select = bus.wdata[5:4];
            st_next.ps   = bus.wdata[3:0];
        end else if (bus.wr && bus.addr == mtmr_pkg::ADDR_MOD) begin
            st_next.modulo = bus.wdata;
            st_next.count  = mtmr_pkg::ZERO8;
            st_next.presc  = mtmr_pkg::ZERO8;
            st_next.overflow_flag    = 1'b0;
            st_next.armed  = 1'b0;
        end
        if (tick && wrap && !(bus.wr && bus.addr == mtmr_pkg::ADDR_MOD)
            && !(bus.wr && bus.addr == mtmr_pkg::ADDR_SC && bus.wdata[mtmr_pkg::BIT_TRST])) begin
            st_next.overflow_flag   = 1'b1;
            st_next.armed = 1'b0;
        end
        st_next.irq = st_next.overflow_flag & st_next.overflow_irq_enable;
        st_next.rdata = mtmr_pkg::ZERO8;
        if (bus.rd) begin
            if (bus.addr == mtmr_pkg::ADDR_SC) begin
                st_next.rdata = {st_reg.overflow_flag, st_reg.overflow_irq_enable, 1'b0, st_reg.stop, 4'h0};
            end else if (bus.addr == mtmr_pkg::ADDR_CLK) begin
                st_next.rdata = {2'h0, st_reg.clock_source_select, st_reg.ps};
            end else if (bus.addr == mtmr_pkg::ADDR_CNT) begin
                st_next.rdata = st_reg.count;
            end else begin
                st_next.rdata = st_reg.modulo;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg      <= '0;
            st_reg.stop <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata        = st_reg.rdata;
    assign overflow_irq = st_reg.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    wrap_sets_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        tick && wrap && !bus.wr |=> st_reg.overflow_flag && st_reg.count == 8'h00)
        else $error("overflow did not set flag");
    stop_holds_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.stop && !bus.wr |=> $stable(st_reg.count))
        else $error("count moved while stopped");
    mod_write_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == mtmr_pkg::ADDR_MOD |=> st_reg.count == 8'h00 && !st_reg.overflow_flag)
        else $error("modulo write did not clear");
    irq_follow_a: assert property (@(posedge clock) disable iff (!nrst)
        ##1 overflow_irq == (st_reg.overflow_flag && st_reg.overflow_irq_enable))
        else $error("irq mismatch");
    count_bound_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.modulo != 8'h00 && st_reg.count <= st_reg.modulo && !bus.wr |=> st_reg.count <= st_reg.modulo)
        else $error("count passed modulo");
    trst_read_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.rd && bus.addr == mtmr_pkg::ADDR_SC |=> !rdata[mtmr_pkg::BIT_TRST])
        else $error("reset bit read nonzero");
    clear_cancel_a: assert property (@(posedge clock) disable iff (!nrst)
        tick && wrap && !bus.wr ##1 bus.wr && bus.addr == mtmr_pkg::ADDR_SC
        && !bus.wdata[mtmr_pkg::BIT_TRST] |=> st_reg.overflow_flag)
        else $error("flag lost after new overflow");
    trst_clear_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == mtmr_pkg::ADDR_SC && bus.wdata[mtmr_pkg::BIT_TRST] |=> !st_reg.overflow_flag)
        else $error("reset bit did not clear flag");
    trst_count_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == mtmr_pkg::ADDR_SC && bus.wdata[mtmr_pkg::BIT_TRST] |=> st_reg.count == 8'h00)
        else $error("reset bit did not clear count");
    tof_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.overflow_flag && !bus.wr |=> st_reg.overflow_flag)
        else $error("flag fell without a write");
    unarmed_keep_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.overflow_flag && !st_reg.armed && bus.wr && bus.addr == mtmr_pkg::ADDR_SC
        && !bus.wdata[mtmr_pkg::BIT_TRST] |=> st_reg.overflow_flag)
        else $error("flag cleared without status read");
    armed_clear_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.armed && !(tick && wrap) && bus.wr && bus.addr == mtmr_pkg::ADDR_SC
        && !bus.wdata[mtmr_pkg::BIT_TOF] |=> !st_reg.overflow_flag)
        else $error("armed clear did not clear flag");
    read_arms_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.rd && bus.addr == mtmr_pkg::ADDR_SC && st_reg.overflow_flag && !(tick && wrap) |=> st_reg.armed)
        else $error("status read did not arm clear");
    overflow_disarm_a: assert property (@(posedge clock) disable iff (!nrst)
        tick && wrap && !bus.wr |=> !st_reg.armed)
        else $error("overflow left clear armed");
    stop_write_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == mtmr_pkg::ADDR_SC |=> st_reg.stop == $past(bus.wdata[mtmr_pkg::BIT_COUNTER_STOP_BIT]))
        else $error("stop bit not taken");
    stop_no_tick_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.stop |-> !tick)
        else $error("tick while stopped");
    tick_inc_a: assert property (@(posedge clock) disable iff (!nrst)
        tick && !wrap && !bus.wr |=> st_reg.count == $past(st_reg.count) + 8'h01)
        else $error("count did not step");
    free_run_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.modulo == 8'h00 && st_reg.count != 8'hFF && tick && !bus.wr |=> st_reg.count != 8'h00)
        else $error("free run wrapped early");
    cfg_keep_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == mtmr_pkg::ADDR_CLK && !tick |=> $stable(st_reg.count))
        else $error("config write moved count");
    cfg_write_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == mtmr_pkg::ADDR_CLK
        |=> st_reg.ps == $past(bus.wdata[3:0]) && st_reg.clock_source_select == $past(bus.wdata[5:4]))
        else $error("clock config not taken");
    bus_source_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.clock_source_select == mtmr_pkg::SRC_BUS |-> src_tick)
        else $error("bus source gave no tick");
    div_one_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.ps == 4'h0 && !st_reg.stop && src_tick |-> tick)
        else $error("divide by one skipped a tick");
    div_max_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.ps >= mtmr_pkg::PS_MAX && tick |-> st_reg.presc == 8'hFF)
        else $error("large code not divide by 256");
    src_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.clock_source_select != mtmr_pkg::SRC_BUS && src_tick && !bus.wr |=> !src_tick)
        else $error("source tick longer than one cycle");
    presc_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        st_reg.ps != 4'h0 && tick && !bus.wr |=> !tick)
        else $error("prescaled tick longer than one cycle");
endmodule

// ==== sim/tb_modulo_overflow_timer.sv ====
`timescale 1ns/1ns
module tb_modulo_overflow_timer;
    logic       clock;
    logic       nrst;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       fixed_freq_clock;
    logic       external_timer_clock_pin;
    logic       overflow_irq;
    logic [7:0] seen;
    int         bad_count;
    int         cmp_count;

    mtmr_timer uut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fixed_freq_clock(fixed_freq_clock), .external_timer_clock_pin(external_timer_clock_pin),
        .overflow_irq(overflow_irq));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("mismatches %0d of %0d compares", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_reg(input string what, input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        check(what, d, exp);
    endtask

    // pulses on the pin, or on the fixed clock input; settles past the sync lag
    task automatic pulses(input int n, input logic on_fixed);
        repeat (n) begin
            @(posedge clock);
            fixed_freq_clock         <= on_fixed;
            external_timer_clock_pin <= !on_fixed;
            repeat (6) @(posedge clock);
            fixed_freq_clock         <= 1'b0;
            external_timer_clock_pin <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_reg("sc after reset", mtmr_pkg::ADDR_SC, 8'h10);
        chk_reg("clk after reset", mtmr_pkg::ADDR_CLK, 8'h00);
        chk_reg("cnt after reset", mtmr_pkg::ADDR_CNT, 8'h00);
        chk_reg("mod after reset", mtmr_pkg::ADDR_MOD, 8'h00);
        check("irq after reset", {7'h00, overflow_irq}, 8'h00);
    endtask

    task automatic t_modulo_and_flag();
        wr_reg(mtmr_pkg::ADDR_MOD, 8'h03);
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h30);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h00);
        pulses(3, 1'b0);
        chk_reg("cnt at modulo", mtmr_pkg::ADDR_CNT, 8'h03);
        chk_reg("no flag yet", mtmr_pkg::ADDR_SC, 8'h00);
        pulses(1, 1'b0);
        chk_reg("cnt wrapped", mtmr_pkg::ADDR_CNT, 8'h00);
        pulses(4, 1'b0);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h00);
        chk_reg("flag needs read", mtmr_pkg::ADDR_SC, 8'h80);
        pulses(4, 1'b0);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h00);
        chk_reg("clear cancelled", mtmr_pkg::ADDR_SC, 8'h80);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h00);
        chk_reg("flag cleared", mtmr_pkg::ADDR_SC, 8'h00);
        pulses(5, 1'b0);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h20);
        chk_reg("cnt after trst", mtmr_pkg::ADDR_CNT, 8'h00);
        chk_reg("sc after trst", mtmr_pkg::ADDR_SC, 8'h00);
    endtask

    task automatic t_irq();
        wr_reg(mtmr_pkg::ADDR_SC, 8'h40);
        pulses(4, 1'b0);
        check("irq raised", {7'h00, overflow_irq}, 8'h01);
        wr_reg(mtmr_pkg::ADDR_MOD, 8'h03);
        chk_reg("mod write clears", mtmr_pkg::ADDR_SC, 8'h40);
        check("irq dropped", {7'h00, overflow_irq}, 8'h00);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h00);
    endtask

    task automatic t_prescale();
        logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
        int         div;
        foreach (codes[i]) begin
            div = (codes[i] > mtmr_pkg::PS_MAX) ? 256 : (1 << codes[i]);
            wr_reg(mtmr_pkg::ADDR_SC, 8'h20);
            wr_reg(mtmr_pkg::ADDR_CLK, {4'h3, codes[i]});
            pulses(div - 1, 1'b0);
            chk_reg("before divided tick", mtmr_pkg::ADDR_CNT, 8'h00);
            pulses(1, 1'b0);
            chk_reg("divided tick", mtmr_pkg::ADDR_CNT, 8'h01);
        end
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h30);
        pulses(1, 1'b0);
        chk_reg("count kept on new rate", mtmr_pkg::ADDR_CNT, 8'h02);
    endtask

    task automatic t_source();
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h20);
        @(posedge clock);
        external_timer_clock_pin <= 1'b1;
        repeat (6) @(posedge clock);
        chk_reg("rise ignored on fall", mtmr_pkg::ADDR_CNT, 8'h02);
        @(posedge clock);
        external_timer_clock_pin <= 1'b0;
        repeat (6) @(posedge clock);
        chk_reg("fall counted", mtmr_pkg::ADDR_CNT, 8'h03);
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h10);
        pulses(1, 1'b0);
        chk_reg("pin ignored on fixed", mtmr_pkg::ADDR_CNT, 8'h03);
        pulses(1, 1'b1);
        chk_reg("fixed counted", mtmr_pkg::ADDR_CNT, 8'h00);
        wr_reg(mtmr_pkg::ADDR_MOD, 8'h00);
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h30);
        pulses(255, 1'b0);
        chk_reg("free run top", mtmr_pkg::ADDR_CNT, 8'hFF);
        pulses(1, 1'b0);
        chk_reg("free run wrap", mtmr_pkg::ADDR_CNT, 8'h00);
        chk_reg("free run flag", mtmr_pkg::ADDR_SC, 8'h80);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h10);
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h00);
        repeat (20) @(posedge clock);
        chk_reg("stopped holds", mtmr_pkg::ADDR_CNT, 8'h00);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h00);
        repeat (20) @(posedge clock);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h10);
        rd_reg(mtmr_pkg::ADDR_CNT, seen);
        check("bus clock counts", seen, 8'h16);
    endtask

    // register read back, ignored count write, reset in mid-run
    task automatic t_regs();
        wr_reg(mtmr_pkg::ADDR_CNT, 8'h55);
        chk_reg("cnt write ignored", mtmr_pkg::ADDR_CNT, 8'h16);
        wr_reg(mtmr_pkg::ADDR_MOD, 8'hFF);
        chk_reg("mod readback", mtmr_pkg::ADDR_MOD, 8'hFF);
        chk_reg("cnt after mod write", mtmr_pkg::ADDR_CNT, 8'h00);
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h2A);
        chk_reg("clk readback", mtmr_pkg::ADDR_CLK, 8'h2A);
        wr_reg(mtmr_pkg::ADDR_CLK, 8'h00);
        wr_reg(mtmr_pkg::ADDR_SC, 8'h40);
        repeat (10) @(posedge clock);
        chk_reg("cnt before reset", mtmr_pkg::ADDR_CNT, 8'h0B);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        nrst                     = 1'b0;
        addr                     = 2'h0;
        wdata                    = 8'h00;
        wr                       = 1'b0;
        rd                       = 1'b0;
        fixed_freq_clock         = 1'b0;
        external_timer_clock_pin = 1'b0;
        bad_count                = 0;
        cmp_count                = 0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_modulo_and_flag();
        t_irq();
        t_prescale();
        t_source();
        t_regs();
        stop_test();
    end

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule
